//--- core/usart_sync_map.vh
// Register map and field positions of the synchronous serial port
`ifndef USART_SYNC_MAP_VH
`define USART_SYNC_MAP_VH

`define OFS_PERIPHERAL_INTERRUPT_FLAGS   8'h0c
`define OFS_RECEIVE_STATUS_CONTROL       8'h18
`define OFS_TRANSMIT_BUFFER              8'h19
`define OFS_RECEIVE_BUFFER               8'h1a
`define OFS_PERIPHERAL_INTERRUPT_ENABLES 8'h8c
`define OFS_TRANSMIT_STATUS_CONTROL      8'h98
`define OFS_BAUD_RATE_DIVISOR            8'h99

`define RST_PERIPHERAL_INTERRUPT_FLAGS   8'h00
`define RST_RECEIVE_STATUS_CONTROL       8'h00
`define RST_TRANSMIT_BUFFER              8'h00
`define RST_RECEIVE_BUFFER               8'h00
`define RST_PERIPHERAL_INTERRUPT_ENABLES 8'h00
`define RST_TRANSMIT_STATUS_CONTROL      8'h02
`define RST_BAUD_RATE_DIVISOR            8'h00

// Flag and enable registers
`define BIT_RECEIVE_COMPLETE  5
`define BIT_TRANSMIT_EMPTY    4

// Receive status and control
`define BIT_PORT_ENABLE       7
`define BIT_RX_NINE_ENABLE    6
`define BIT_SINGLE_RECEIVE    5
`define BIT_CONT_RECEIVE      4
`define BIT_FRAMING_ERROR     2
`define BIT_OVERRUN_ERROR     1
`define BIT_RX_NINTH          0

// Transmit status and control
`define BIT_MASTER_CLOCK      7
`define BIT_TX_NINE_ENABLE    6
`define BIT_TRANSMIT_ENABLE   5
`define BIT_SYNC_SELECT       4
`define BIT_HIGH_SPEED        2
`define BIT_SHIFT_EMPTY       1
`define BIT_TX_NINTH          0

// Word lengths in bits
`define BITS_SHORT_WORD       4'd8
`define BITS_LONG_WORD        4'd9

`endif

//--- core/usart_sync_master_port.v
// Synchronous master/slave serial port with register file and pin control
//
// Behaviour
// - Shift register reloads only after its last bit, then at once if data.
// - Buffer-to-shift move takes one cycle, then buffer-empty flag sets.
// - Buffer-empty flag ignores enable, software cannot clear, write clears.
// - Read-only shift-empty bit high whenever shift register is empty.
// - Shifting starts once buffer holds data; bits driven on rising edges.
// - Rate generator held reset when all enables clear; runs at once.
// - Write into empty shift register passes straight through.
// - Clearing transmit enable aborts, resets transmitter, releases both pins unless a receive enable is set.
// - Receive enable suspends transmit, releases data, clock driven if master.
// - Single receive self-clears; transmit then resumes driving data.
// - Ninth transmit bit sampled when word moves into shift register.
// - Either receive enable starts reception; samples on falling edge.
// - Single receive takes one word; continuous wins when both set.
// - Finished word moves into buffer if room; receive flag sets.
// - Receive flag clears only when reads empty the buffer.
// - Two-word FIFO; third word while full is lost, sets overrun in continuous receive only.
// - Overrun blocks transfers; clearing continuous receive clears it.
// - Ninth received bit queued with data; read advances it.
// - Master clock bit clear selects external shift clock.
// - Sync select plus port enable hand pins to clock and data.
// - Half-duplex: reception blocks transmission; transmission does not block reception.
`timescale 1ns/1ps
`include "usart_sync_map.vh"

module usart_sync_master_port
(
   input  wire       core_clk,
   input  wire       resetn,
   input  wire [7:0] reg_addr,
   input  wire [7:0] reg_wdata,
   input  wire       reg_write,
   input  wire       reg_read,
   output reg  [7:0] reg_rdata,
   input  wire       sync_clock_line_in,
   output reg        sync_clock_line_out,
   output reg        sync_clock_line_oe,
   input  wire       sync_data_line_in,
   output reg        sync_data_line_out,
   output reg        sync_data_line_oe,
   output reg        transmit_interrupt,
   output reg        receive_interrupt
);

   reg        rst_meta_n;
   reg        rst_n;

   // Control fields
   reg        port_enable;
   reg        receive_nine_bit_enable;
   reg        single_receive_enable;
   reg        continuous_receive_enable;
   reg        overrun_error_bit;
   reg        master_clock_source_select;
   reg        transmit_nine_bit_enable;
   reg        transmit_enable;
   reg        sync_select;
   reg        high_speed;
   reg        transmit_ninth_bit;
   reg        transmit_interrupt_enable;
   reg        receive_interrupt_enable;
   reg [7:0]  baud_rate_divisor;

   // Transmit path
   reg [7:0]  transmit_buffer;
   reg        tx_buffer_full;
   reg        transmit_buffer_empty_flag;
   reg [8:0]  transmit_shift_register;
   reg        tx_busy;
   reg [3:0]  tx_bits_left;

   // Receive path
   reg [8:0]  receive_shift_register;
   reg [3:0]  rx_bits_done;
   reg [8:0]  rx_fifo [0:1];
   reg        rx_head;
   reg [1:0]  rx_count;

   // Shift clock
   reg [7:0]  baud_rate_generator;
   reg        clock_level;
   reg        ext_clock_prev;

   wire       port_on   = port_enable & sync_select;
   wire       rx_enable = single_receive_enable | continuous_receive_enable;
   wire       brg_run   = transmit_enable | rx_enable;
   wire       tx_mode   = port_on & transmit_enable & ~rx_enable;
   wire       rx_mode   = port_on & rx_enable;
   wire       shifting  = rx_mode | (tx_mode & tx_busy);
   wire       brg_tick  = brg_run & (baud_rate_generator == 8'h00);
   wire [3:0] tx_len    = transmit_nine_bit_enable ? `BITS_LONG_WORD
                                                   : `BITS_SHORT_WORD;
   wire [3:0] rx_len    = receive_nine_bit_enable ? `BITS_LONG_WORD
                                                  : `BITS_SHORT_WORD;
   wire       receive_complete_flag = (rx_count != 2'd0);
   wire [8:0] rx_head_word = rx_fifo[rx_head];

   wire       wr_receive_status_control = reg_write &
                         (reg_addr == `OFS_RECEIVE_STATUS_CONTROL);
   wire       wr_transmit_status_control = reg_write &
                         (reg_addr == `OFS_TRANSMIT_STATUS_CONTROL);
   wire       wr_txbuf = reg_write & (reg_addr == `OFS_TRANSMIT_BUFFER);
   wire       rd_rxbuf = reg_read & (reg_addr == `OFS_RECEIVE_BUFFER);

   // Shift edges: rate generator in master, clock pin in slave
   reg        shift_rise;
   reg        shift_fall;
   always @*
   begin
      shift_rise = 1'b0;
      shift_fall = 1'b0;
      if (!master_clock_source_select)
      begin
         shift_rise = shifting & sync_clock_line_in & ~ext_clock_prev;
         shift_fall = shifting & ~sync_clock_line_in & ext_clock_prev;
      end
      else if (shifting & brg_tick)
      begin
         shift_rise = ~clock_level;
         shift_fall = clock_level;
      end
   end

   wire       rx_word_done = rx_mode & shift_fall &
                             (rx_bits_done == rx_len - 4'd1);
   wire       tx_load = tx_mode & ~tx_busy & tx_buffer_full;
   wire       tx_last = tx_mode & tx_busy & shift_fall &
                        (tx_bits_left == 4'd0);

   // Reset release through two flops
   always @(posedge core_clk or negedge resetn)
   begin
      if (!resetn)
      begin
         rst_meta_n <= 1'b0;
         rst_n      <= 1'b0;
      end
      else
      begin
         rst_meta_n <= 1'b1;
         rst_n      <= rst_meta_n;
      end
   end

   // Baud rate generator and master clock level
   always @(posedge core_clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         baud_rate_generator <= `RST_BAUD_RATE_DIVISOR;
         clock_level         <= 1'b0;
         ext_clock_prev      <= 1'b0;
      end
      else
      begin
         ext_clock_prev <= sync_clock_line_in;
         // Held while idle, reloads each half period
         if (!brg_run || brg_tick)
            baud_rate_generator <= baud_rate_divisor;
         else
            baud_rate_generator <= baud_rate_generator - 8'h01;
         if (!shifting || !master_clock_source_select)
            clock_level <= 1'b0;
         else if (brg_tick)
            clock_level <= ~clock_level;
      end
   end

   // Control registers and software writes
   always @(posedge core_clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         port_enable                <= 1'b0;
         receive_nine_bit_enable    <= 1'b0;
         single_receive_enable      <= 1'b0;
         continuous_receive_enable  <= 1'b0;
         master_clock_source_select <= 1'b0;
         transmit_nine_bit_enable   <= 1'b0;
         transmit_enable            <= 1'b0;
         sync_select                <= 1'b0;
         high_speed                 <= 1'b0;
         transmit_ninth_bit         <= 1'b0;
         transmit_interrupt_enable  <= 1'b0;
         receive_interrupt_enable   <= 1'b0;
         baud_rate_divisor          <= `RST_BAUD_RATE_DIVISOR;
      end
      else
      begin
         // Single receive ends after one word
         if (rx_word_done && !continuous_receive_enable)
            single_receive_enable <= 1'b0;
         if (wr_receive_status_control)
         begin
            port_enable               <= reg_wdata[`BIT_PORT_ENABLE];
            receive_nine_bit_enable   <= reg_wdata[`BIT_RX_NINE_ENABLE];
            single_receive_enable     <= reg_wdata[`BIT_SINGLE_RECEIVE];
            continuous_receive_enable <= reg_wdata[`BIT_CONT_RECEIVE];
         end
         if (wr_transmit_status_control)
         begin
            master_clock_source_select <= reg_wdata[`BIT_MASTER_CLOCK];
            transmit_nine_bit_enable   <= reg_wdata[`BIT_TX_NINE_ENABLE];
            transmit_enable            <= reg_wdata[`BIT_TRANSMIT_ENABLE];
            sync_select                <= reg_wdata[`BIT_SYNC_SELECT];
            high_speed                 <= reg_wdata[`BIT_HIGH_SPEED];
            transmit_ninth_bit         <= reg_wdata[`BIT_TX_NINTH];
         end
         if (reg_write && reg_addr == `OFS_PERIPHERAL_INTERRUPT_ENABLES)
         begin
            transmit_interrupt_enable <= reg_wdata[`BIT_TRANSMIT_EMPTY];
            receive_interrupt_enable  <= reg_wdata[`BIT_RECEIVE_COMPLETE];
         end
         if (reg_write && reg_addr == `OFS_BAUD_RATE_DIVISOR)
            baud_rate_divisor <= reg_wdata;
      end
   end

   // Transmit buffer and shift register
   always @(posedge core_clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         transmit_buffer            <= `RST_TRANSMIT_BUFFER;
         tx_buffer_full             <= 1'b0;
         transmit_buffer_empty_flag <= 1'b0;
         transmit_shift_register    <= 9'h000;
         tx_busy                    <= 1'b0;
         tx_bits_left               <= 4'd0;
      end
      else
      begin
         // Transmit enable low resets the transmitter
         if (!transmit_enable)
         begin
            tx_busy      <= 1'b0;
            tx_bits_left <= 4'd0;
         end
         // Reload only when previous word finished
         // Empty shift register takes the word at once
         else if (tx_load)
         begin
            // Ninth bit captured at the move
            transmit_shift_register <= {transmit_ninth_bit,
                                        transmit_buffer};
            tx_busy                 <= 1'b1;
            tx_bits_left            <= tx_len;
         end
         // Next bit on each rising shift edge
         else if (tx_mode && tx_busy && shift_rise && tx_bits_left != 4'd0)
         begin
            transmit_shift_register <= {1'b0,
                                        transmit_shift_register[8:1]};
            tx_bits_left            <= tx_bits_left - 4'd1;
         end
         else if (tx_last)
            tx_busy <= 1'b0;
         // Move done in one cycle, flag sets
         if (tx_load && transmit_enable)
         begin
            tx_buffer_full             <= 1'b0;
            transmit_buffer_empty_flag <= 1'b1;
         end
         // Only a buffer write clears the flag
         if (wr_txbuf)
         begin
            transmit_buffer            <= reg_wdata;
            tx_buffer_full             <= 1'b1;
            transmit_buffer_empty_flag <= 1'b0;
         end
      end
   end

   // Receive shift register and two-word FIFO
   always @(posedge core_clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         receive_shift_register <= 9'h000;
         rx_bits_done           <= 4'd0;
         rx_fifo[0]             <= 9'h000;
         rx_fifo[1]             <= 9'h000;
         rx_head                <= 1'b0;
         rx_count               <= 2'd0;
         overrun_error_bit      <= 1'b0;
      end
      else
      begin
         if (!rx_mode)
            rx_bits_done <= 4'd0;
         else if (shift_fall)
         begin
            receive_shift_register[rx_bits_done] <= sync_data_line_in;
            if (rx_word_done)
               rx_bits_done <= 4'd0;
            else
               rx_bits_done <= rx_bits_done + 4'd1;
         end
         if (!continuous_receive_enable)
            overrun_error_bit <= 1'b0;
         // Third word while full is lost
         else if (rx_word_done && rx_count == 2'd2)
            overrun_error_bit <= 1'b1;
         if (rx_word_done && rx_count != 2'd2 && !overrun_error_bit)
         begin
            rx_fifo[rx_head ^ rx_count[0]] <=
               receive_nine_bit_enable
               ? {sync_data_line_in, receive_shift_register[7:0]}
               : {1'b0, sync_data_line_in,
                  receive_shift_register[6:0]};
         end
         if (rd_rxbuf && rx_count != 2'd0)
            rx_head <= ~rx_head;
         if (rx_word_done && rx_count != 2'd2 && !overrun_error_bit)
         begin
            if (!(rd_rxbuf && rx_count != 2'd0))
               rx_count <= rx_count + 2'd1;
         end
         else if (rd_rxbuf && rx_count != 2'd0)
            rx_count <= rx_count - 2'd1;
      end
   end

   // Pin drivers, interrupt requests and read data
   always @(posedge core_clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         sync_clock_line_out <= 1'b0;
         sync_clock_line_oe  <= 1'b0;
         sync_data_line_out  <= 1'b0;
         sync_data_line_oe   <= 1'b0;
         transmit_interrupt  <= 1'b0;
         receive_interrupt   <= 1'b0;
         reg_rdata           <= 8'h00;
      end
      else
      begin
         // Pins belong to the port only when enabled
         // Master clock stays driven while receiving
         sync_clock_line_oe  <= port_on & master_clock_source_select &
                                brg_run;
         sync_clock_line_out <= clock_level;
         // Transmit resumes once single receive ends
         sync_data_line_oe   <= tx_mode;
         if (tx_mode && tx_busy && shift_rise && tx_bits_left != 4'd0)
            sync_data_line_out <= transmit_shift_register[0];
         transmit_interrupt  <= transmit_buffer_empty_flag &
                                transmit_interrupt_enable;
         receive_interrupt   <= receive_complete_flag &
                                receive_interrupt_enable;
         reg_rdata <= 8'h00;
         if (reg_read)
         begin
            if (reg_addr == `OFS_PERIPHERAL_INTERRUPT_FLAGS)
               reg_rdata <= {2'b00, receive_complete_flag,
                             transmit_buffer_empty_flag, 4'h0};
            else if (reg_addr == `OFS_RECEIVE_STATUS_CONTROL)
               reg_rdata <= {port_enable, receive_nine_bit_enable,
                             single_receive_enable,
                             continuous_receive_enable, 2'b00,
                             overrun_error_bit, rx_head_word[8]};
            else if (reg_addr == `OFS_TRANSMIT_BUFFER)
               reg_rdata <= transmit_buffer;
            else if (reg_addr == `OFS_RECEIVE_BUFFER)
               reg_rdata <= rx_head_word[7:0];
            else if (reg_addr == `OFS_PERIPHERAL_INTERRUPT_ENABLES)
               reg_rdata <= {2'b00, receive_interrupt_enable,
                             transmit_interrupt_enable, 4'h0};
            else if (reg_addr == `OFS_TRANSMIT_STATUS_CONTROL)
               reg_rdata <= {master_clock_source_select,
                             transmit_nine_bit_enable, transmit_enable,
                             sync_select, 1'b0, high_speed, ~tx_busy,
                             transmit_ninth_bit};
            else if (reg_addr == `OFS_BAUD_RATE_DIVISOR)
               reg_rdata <= baud_rate_divisor;
         end
      end
   end

endmodule

//--- sim/serial_peer_model.sv
// Peripheral on the far end of the synchronous link, clocked by the port
`timescale 1ns/1ps
module serial_peer_model
(
   input  wire  core_clk,
   input  wire  sync_clock_line,
   input  wire  sync_data_line,
   input  wire  device_drives,
   output logic peer_data
);
   bit   feed[$];
   bit   heard[$];
   logic junk = 1'b0;
   logic cur = 1'b0;
   logic have = 1'b0;
   // Idle line toggles so a stale level never passes for data
   always @(posedge core_clk)
      junk <= ~junk;
   assign peer_data = have ? cur : junk;
   always @(posedge sync_clock_line)
      if (!device_drives && feed.size() > 0)
      begin
         cur <= feed.pop_front();
         have <= 1'b1;
      end
   always @(negedge sync_clock_line)
   begin
      if (device_drives)
         heard.push_back(sync_data_line);
      if (feed.size() == 0)
         have <= 1'b0;
   end
endmodule

//--- sim/usart_sync_master_port_assertions.sv
// Concurrent checks on the serial port's register bus and pins
`timescale 1ns/1ps
module usart_sync_checker
(
   input wire       core_clk,
   input wire       resetn,
   input wire [7:0] reg_addr,
   input wire [7:0] reg_wdata,
   input wire       reg_write,
   input wire       reg_read,
   input wire [7:0] reg_rdata,
   input wire       sync_clock_line_in,
   input wire       sync_clock_line_out,
   input wire       sync_clock_line_oe,
   input wire       sync_data_line_in,
   input wire       sync_data_line_out,
   input wire       sync_data_line_oe,
   input wire       transmit_interrupt,
   input wire       receive_interrupt
);
   default clocking @(posedge core_clk); endclocking
   default disable iff (!resetn);
   wire      unmapped = !(reg_addr inside
      {8'h0c, 8'h18, 8'h19, 8'h1a, 8'h8c, 8'h98, 8'h99});
   logic [8:0] high_run;
   // Long high phase means the divisor is not obeyed
   always @(posedge core_clk or negedge resetn)
      if (!resetn)
         high_run <= 9'h000;
      else if (sync_clock_line_out)
         high_run <= high_run + 9'h001;
      else
         high_run <= 9'h000;
   a_unmapped_read: assert property (
      reg_read && unmapped |=> reg_rdata == 8'h00)
      else $error("unmapped read returned data");
   a_rdata_pulse: assert property (
      reg_rdata != 8'h00 |-> $past(reg_read))
      else $error("read data outside its cycle");
   a_flag_write_kept: assert property (
      transmit_interrupt && reg_write && reg_addr == 8'h0c
      |=> transmit_interrupt)
      else $error("software write cleared buffer empty flag");
   a_data_steady_fall: assert property (
      $fell(sync_clock_line_out) && sync_data_line_oe
      |-> $stable(sync_data_line_out))
      else $error("data moved at falling clock");
   a_receive_aborts: assert property (
      reg_write && reg_addr == 8'h18 && reg_wdata[7]
      && reg_wdata[5:4] != 2'b00 |-> ##[1:3] !sync_data_line_oe)
      else $error("data line kept driven for reception");
   a_disable_releases: assert property (
      reg_write && reg_addr == 8'h98 && !reg_wdata[5]
      |-> ##[1:3] !sync_data_line_oe)
      else $error("data line driven after transmit off");
   a_port_off: assert property (
      reg_write && reg_addr == 8'h18 && !reg_wdata[7]
      |-> ##[1:3] !sync_clock_line_oe && !sync_data_line_oe)
      else $error("pins driven with port off");
   a_clock_bounded: assert property (
      high_run <= 9'd256)
      else $error("clock high beyond longest half period");
   c_tx_irq: cover property ($rose(transmit_interrupt));
   c_rx_irq: cover property ($rose(receive_interrupt));
   c_rx_clock: cover property (sync_clock_line_oe && !sync_data_line_oe
      && $rose(sync_clock_line_out));
endmodule
bind usart_sync_master_port usart_sync_checker chk (.*);

//--- sim/test_usart_sync_master_port.sv
// Self-checking bench for the synchronous serial port
`timescale 1ns/1ps
`define check(g, e) begin logic [15:0] gv; logic [15:0] ev; gv = (g); \
   ev = (e); comparisons++; if (gv !== ev) begin n_errors++; \
   $display("[ERR] %0t got %0h exp %0h", $time, gv, ev); end end
module test_usart_sync_master_port;
   logic       core_clk, resetn, reg_write, reg_read;
   logic [7:0] reg_addr, reg_wdata, rd_val;
   wire  [7:0] reg_rdata;
   wire        clk_out, clk_oe, dat_out, dat_oe, tx_irq, rx_irq, peer_data;
   wire        clock_level = clk_oe ? clk_out : 1'b0;
   wire        data_level = dat_oe ? dat_out : peer_data;
   int         n_errors = 0;
   int         comparisons = 0;
   logic [7:0] seed = 8'h3c;
   bit         exp_bits[$];
   logic [8:0] exp_rx[$];
   logic [7:0] map_addr[8] = '{8'h0c, 8'h18, 8'h19, 8'h1a, 8'h8c,
      8'h98, 8'h99, 8'h55};
   logic [7:0] map_rst[8] = '{0, 0, 0, 0, 0, 8'h02, 0, 0};
   usart_sync_master_port dut
   (
      .core_clk            (core_clk),
      .resetn              (resetn),
      .reg_addr            (reg_addr),
      .reg_wdata           (reg_wdata),
      .reg_write           (reg_write),
      .reg_read            (reg_read),
      .reg_rdata           (reg_rdata),
      .sync_clock_line_in  (clock_level),
      .sync_clock_line_out (clk_out),
      .sync_clock_line_oe  (clk_oe),
      .sync_data_line_in   (data_level),
      .sync_data_line_out  (dat_out),
      .sync_data_line_oe   (dat_oe),
      .transmit_interrupt  (tx_irq),
      .receive_interrupt   (rx_irq)
   );
   serial_peer_model peer
   (
      .core_clk        (core_clk),
      .sync_clock_line (clock_level),
      .sync_data_line  (data_level),
      .device_drives   (dat_oe),
      .peer_data       (peer_data)
   );
   initial
   begin
      core_clk = 1'b0;
      forever #5 core_clk = ~core_clk;
   end
   function automatic logic [7:0] lfsr(input logic [7:0] s);
      lfsr = {s[6:0], s[7] ^ s[5] ^ s[4] ^ s[3]};
   endfunction
   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      @(posedge core_clk);
      reg_addr <= a;
      reg_wdata <= d;
      reg_write <= 1'b1;
      @(posedge core_clk);
      reg_write <= 1'b0;
   endtask
   task automatic rd(input logic [7:0] a);
      @(posedge core_clk);
      reg_addr <= a;
      reg_read <= 1'b1;
      @(posedge core_clk);
      reg_read <= 1'b0;
      @(negedge core_clk);
      rd_val = reg_rdata;
   endtask
   // Polling is bounded so a stuck flag ends in a mismatch, not a hang
   task automatic poll(input logic [7:0] a, input logic [7:0] m);
      int i;
      i = 0;
      do
      begin
         rd(a);
         i++;
      end
      while ((rd_val & m) !== m && i < 400);
   endtask
   task automatic send(input logic [7:0] d, input logic [1:0] n9);
      for (int k = 0; k < 8; k++)
         exp_bits.push_back(d[k]);
      if (n9[1])
         exp_bits.push_back(n9[0]);
      wr(8'h19, d);
   endtask
   task automatic finish_tx;
      int i;
      i = 0;
      while (peer.heard.size() < exp_bits.size() && i < 3000)
      begin
         @(posedge core_clk);
         i++;
      end
      `check(peer.heard.size(), exp_bits.size())
      while (exp_bits.size() > 0 && peer.heard.size() > 0)
         `check(peer.heard.pop_front(), exp_bits.pop_front())
      poll(8'h98, 8'h02);
      `check(rd_val[1], 1'b1)
   endtask
   task automatic report_and_stop;
      $display("comparisons %0d mismatches %0d", comparisons, n_errors);
      if (n_errors == 0 && comparisons > 0)
         $display("bench passed");
      else
         $display("bench failed");
      $finish;
   endtask
   initial
   begin
      repeat (40000) @(posedge core_clk);
      n_errors++;
      report_and_stop();
   end
   initial
   begin
      logic [7:0] a;
      logic [7:0] b;
      logic [8:0] w;
      resetn = 1'b0;
      reg_addr = 8'h00;
      reg_wdata = 8'h00;
      reg_write = 1'b0;
      reg_read = 1'b0;
      repeat (2) @(posedge core_clk);
      resetn <= 1'b1;
      repeat (3) @(posedge core_clk);
      for (int i = 0; i < 8; i++)
      begin
         rd(map_addr[i]);
         `check(rd_val, map_rst[i])
      end
      $display("test reset done");
      wr(8'h99, 8'h03); // divisor before mode
      wr(8'h18, 8'h80); // both receive enables clear
      wr(8'h98, 8'hb0);
      // Enable lands at this edge, the pin enable one edge later
      repeat (2) @(negedge core_clk);
      `check(clk_oe, 1'b1)
      wr(8'h0c, 8'hff);
      rd(8'h0c);
      `check(rd_val, 8'h00)
      seed = lfsr(seed);
      a = seed;
      seed = lfsr(seed);
      b = seed;
      send(a, 2'b00);
      send(b, 2'b00);
      rd(8'h0c);
      `check(rd_val[4], 1'b0)
      rd(8'h98);
      `check(rd_val, 8'hb0)
      wr(8'h8c, 8'h10);
      finish_tx();
      rd(8'h0c);
      `check(rd_val, 8'h10)
      wr(8'h0c, 8'h00);
      `check(tx_irq, 1'b1)
      // Ninth bit is sampled at the move, so the second word sees 0
      wr(8'h98, 8'hf1); // ninth bit before data
      send(a, 2'b11);
      wr(8'h98, 8'hf0);
      send(b, 2'b10);
      rd(8'h0c);
      `check(rd_val[4], 1'b0)
      finish_tx();
      $display("test transmit done");
      send(a, 2'b00);
      repeat (20) @(posedge core_clk);
      wr(8'h98, 8'h90);
      repeat (2) @(posedge core_clk);
      `check({clk_oe, dat_oe}, 2'b00)
      rd(8'h98);
      `check(rd_val, 8'h92)
      wr(8'h98, 8'hb0);
      wr(8'h19, b);
      repeat (12) @(posedge core_clk);
      for (int k = 0; k < 8; k++)
         peer.feed.push_back(a[k]);
      wr(8'h18, 8'ha0);
      repeat (3) @(posedge core_clk);
      `check({clk_oe, dat_oe}, 2'b10)
      poll(8'h0c, 8'h20);
      rd(8'h18);
      `check(rd_val[5:4], 2'b00)
      `check(dat_oe, 1'b1)
      rd(8'h1a);
      wr(8'h98, 8'h90);
      peer.feed.delete();
      peer.heard.delete();
      exp_bits.delete();
      $display("test abort done");
      for (int i = 0; i < 3; i++)
      begin
         seed = lfsr(seed);
         w = {seed[0], seed};
         exp_rx.push_back(w);
         for (int k = 0; k < 9; k++)
            peer.feed.push_back(w[k]);
      end
      wr(8'h8c, 8'h20);
      wr(8'h18, 8'hf0);
      poll(8'h18, 8'h02);
      `check(rx_irq, 1'b1)
      for (int i = 0; i < 2; i++)
      begin
         w = exp_rx.pop_front();
         rd(8'h18);
         `check(rd_val & 8'h17, 8'h12 | {7'h00, w[8]})
         rd(8'h1a);
         `check(rd_val, w[7:0])
      end
      repeat (3) @(posedge core_clk);
      `check(rx_irq, 1'b0)
      exp_rx.delete();
      wr(8'h18, 8'hc0);
      rd(8'h18);
      `check(rd_val & 8'hfe, 8'hc0)
      $display("test receive done");
      wr(8'h18, 8'h00);
      repeat (3) @(posedge core_clk);
      `check({clk_oe, dat_oe}, 2'b00)
      $display("test port off done");
      report_and_stop();
   end
endmodule
